// >>> hw/adc_select_pkg.sv
// Operation
// - single-ended result is unsigned code, Vin*1024/Vref, 0x000 to 0x3FF
// - differential result is two's complement diff*gain*512/Vref, 0x200 to 0x1FF
// - differential result bit 9 is the sign, one means negative
// - result registers take the finished result in the same edge the done flag rises
// - reference field bits 7:6 pick external pin, supply, 1.1V or 2.56V
// - selection writes during a conversion take effect only after it completes
// - left-adjust bit 5 re-presents the held result at once, even mid-conversion
// - right: high 1:0 = bits 9:8; left: high = bits 9:2, low 7:6 = 1:0
// - after a low-byte read, no result update until the high byte is read
// - input field bits 4:0, codes 0-7 select single-ended inputs 0-7
// - codes 8-15 select gain pairs against input 0 or 2, 10x or 200x
// - codes 16-29 unity-gain pairs against input 1 or 2; 30 bandgap, 31 ground
// - done flag sets on completion; cleared by writing one or by vector service
package adc_select_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map and widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RES_W = 10;
    localparam logic [7:0] SELECT_OFFSET = 8'h7C;
    localparam logic [7:0] RES_LOW_OFFSET = 8'h78;
    localparam logic [7:0] RES_HIGH_OFFSET = 8'h79;
    localparam logic [7:0] STATUS_OFFSET = 8'h70;
    localparam logic [7:0] MASK_OFFSET = 8'h71;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int DONE_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int REF_LSB = 6;
    localparam int LADJ_BIT = 5;
    localparam int INPUT_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // result limits and gain factors
    localparam int SE_MAX = 1023;
    localparam int DIFF_MAX = 511;
    localparam int DIFF_MIN = -512;
    localparam logic [7:0] GAIN_1X_FACTOR = 8'h01;
    localparam logic [7:0] GAIN_10X_FACTOR = 8'h0A;
    localparam logic [7:0] GAIN_200X_FACTOR = 8'hC8;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {REF_EXT_PIN, REF_ANALOG_SUPPLY, REF_INT_1V1, REF_INT_2V56} reference_t;
    typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} gain_t;
    typedef enum logic [1:0] {SRC_PINS, SRC_BANDGAP, SRC_GROUND} source_t;

    typedef struct packed {
        logic [1:0] reference_field;
        logic left_adjust_bit;
        logic [4:0] input_gain_field;
    } select_reg_t;

    typedef struct packed {
        source_t source;
        logic differential;
        logic [2:0] positive_input;
        logic [2:0] negative_input;
        gain_t gain;
        reference_t reference;
    } analog_select_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic read;
    } reg_req_t;

    localparam analog_select_t ANALOG_SELECT_RESET =
        '{SRC_PINS, 1'b0, 3'h0, 3'h0, GAIN_1X, REF_EXT_PIN};

    // turns the selection fields into what the analog mux and gain stage need
    function automatic analog_select_t decode_select(input select_reg_t sel);
        analog_select_t a;
        a = ANALOG_SELECT_RESET;
        a.reference = reference_t'(sel.reference_field);
        unique case (sel.input_gain_field[4:3])
            2'b00: begin
                a.positive_input = sel.input_gain_field[2:0];
            end
            2'b01: begin
                a.differential = 1'b1;
                a.negative_input = sel.input_gain_field[2] ? 3'h2 : 3'h0;
                a.positive_input = {2'b00, sel.input_gain_field[0]} | a.negative_input;
                a.gain = sel.input_gain_field[1] ? GAIN_200X : GAIN_10X;
            end
            2'b10: begin
                a.differential = 1'b1;
                a.positive_input = sel.input_gain_field[2:0];
                a.negative_input = 3'h1;
            end
            // unity pairs against input 2, then bandgap and ground
            2'b11: begin
                if (sel.input_gain_field[2:1] == 2'b11) begin
                    a.source = sel.input_gain_field[0] ? SRC_GROUND : SRC_BANDGAP;
                end else begin
                    a.differential = 1'b1;
                    a.positive_input = sel.input_gain_field[2:0];
                    a.negative_input = 3'h2;
                end
            end
        endcase
        return a;
    endfunction

endpackage

// >>> hw/result_formatter.sv
`timescale 1ns/100ps
// scales the raw converter sample by the gain and clamps it into the code range
module result_formatter
    import adc_select_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input wire logic signed [SAMPLE_W-1:0] sample, // raw scaled sample
    input wire logic differential,                 // pair mode
    input wire gain_t gain,                        // gain of the pair
    output logic [RES_W-1:0] code                  // 10-bit result code
);
    localparam int PW = SAMPLE_W + 9;
    localparam logic signed [PW-1:0] SE_HI = PW'(SE_MAX);
    localparam logic signed [PW-1:0] DIFF_HI = PW'(DIFF_MAX);
    localparam logic signed [PW-1:0] DIFF_LO = PW'(DIFF_MIN);

    logic [7:0] factor;
    logic signed [PW-1:0] product;

    // gain factor; a single-ended sample is never scaled
    always_comb begin
        unique case (gain)
            GAIN_10X: factor = GAIN_10X_FACTOR;
            GAIN_200X: factor = GAIN_200X_FACTOR;
            default: factor = GAIN_1X_FACTOR;
        endcase
        if (!differential) begin
            factor = GAIN_1X_FACTOR;
        end
        // widen both operands first so a 200x product cannot wrap at the sample width
        product = PW'(sample) * PW'($signed({1'b0, factor}));
    end

    // saturate, since an over-range input must pin at the end codes
    always_comb begin
        if (differential) begin
            if (product > DIFF_HI) begin
                code = 10'h1FF;
            end else if (product < DIFF_LO) begin
                code = 10'h200;
            end else begin
                code = product[RES_W-1:0];
            end
        end else begin
            if (product < 0) begin
                code = 10'h000;
            end else if (product > SE_HI) begin
                code = 10'h3FF;
            end else begin
                code = product[RES_W-1:0];
            end
        end
    end
endmodule

// >>> hw/adc_select_top.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
// selection register, conversion bookkeeping and result presentation
module adc_select_top
    import adc_select_pkg::*;
#(
    parameter int SAMPLE_W = 16
) (
    input wire logic clk,                              // 250 MHz system clock
    input wire logic resetn,                           // async reset, active low
    input wire logic ce,                               // clock enable, freezes all state
    input wire reg_req_t req,                          // register request
    output logic [DATA_W-1:0] rdata,                   // read data, cycle after read
    input wire logic conv_start,                       // pulse: start a conversion
    input wire logic sample_valid,                     // pulse: converter finished
    input wire logic signed [SAMPLE_W-1:0] sample_data, // raw scaled sample
    input wire logic irq_ack,                          // pulse: vector serviced
    output analog_select_t analog_sel,                 // mux, gain and reference setting
    output logic busy,                                 // conversion running
    output logic irq                                   // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration check: the sample must cover the code range and keep the product small
    if (SAMPLE_W < 11 || SAMPLE_W > 23) begin : g_bad_width
        $error("SAMPLE_W must lie between 11 and 23");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state
    select_reg_t select_reg;
    analog_select_t analog_sel_reg;
    logic busy_reg;
    logic [RES_W-1:0] result_reg;
    logic [RES_W-1:0] pending_reg;
    logic pending_valid_reg;
    logic lock_reg;
    logic done_reg;
    logic mask_reg;
    logic [DATA_W-1:0] rdata_reg;

    logic [RES_W-1:0] new_code;
    logic wr_select;
    logic wr_status;
    logic wr_mask;
    logic rd_low;
    logic rd_high;
    logic start;
    logic finish;
    logic locked_now;
    logic take_new;
    logic take_pending;
    logic done_set;
    logic done_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode; unmapped writes are dropped, unmapped reads return zero
    assign wr_select = req.write && (req.addr == SELECT_OFFSET);
    assign wr_status = req.write && (req.addr == STATUS_OFFSET);
    assign wr_mask = req.write && (req.addr == MASK_OFFSET);
    assign rd_low = req.read && (req.addr == RES_LOW_OFFSET);
    assign rd_high = req.read && (req.addr == RES_HIGH_OFFSET);

    // a start while busy is ignored, the running conversion keeps its setting
    assign start = conv_start && !busy_reg;
    assign finish = sample_valid && busy_reg;

    // a low-byte read freezes the data until the high byte is read
    assign locked_now = (lock_reg || rd_low) && !rd_high;
    assign take_new = finish && !locked_now;
    assign take_pending = rd_high && lock_reg && pending_valid_reg && !finish;

    // completion sets, write-one or vector service clears
    assign done_set = take_new || take_pending;
    assign done_clear = (wr_status && req.wdata[DONE_BIT]) || irq_ack;

    ////////////////////////////////////////////////////////////////////////////////
    // selection register, written by software at any time
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            select_reg <= select_reg_t'(SELECT_RESET);
        end else if (ce && wr_select) begin
            select_reg <= select_reg_t'(req.wdata);
        end
    end

    // conversion running flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
        end else if (ce) begin
            if (start) begin
                busy_reg <= 1'b1;
            end else if (finish) begin
                busy_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // analog setting follows the register while idle and is frozen while busy,
    // so the copy taken in the start cycle is the one used to the end
    // shadow latch at start
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            analog_sel_reg <= ANALOG_SELECT_RESET;
        end else if (ce && !busy_reg) begin
            analog_sel_reg <= decode_select(select_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gain and clamp of the raw sample, using the frozen setting
    result_formatter #(
        .SAMPLE_W(SAMPLE_W)
    ) u_formatter (
        .sample(sample_data),
        .differential(analog_sel_reg.differential),
        .gain(analog_sel_reg.gain),
        .code(new_code)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // result register; written in the same edge the done flag rises
    // data and flag in one edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_reg <= '0;
        end else if (ce) begin
            if (take_new) begin
                result_reg <= new_code;
            end else if (take_pending) begin
                result_reg <= pending_reg;
            end
        end
    end

    // a result that finishes while frozen waits here rather than being lost
    // park the blocked result
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pending_reg <= '0;
            pending_valid_reg <= 1'b0;
        end else if (ce) begin
            if (finish && locked_now) begin
                pending_reg <= new_code;
                pending_valid_reg <= 1'b1;
            end else if (take_pending || take_new) begin
                pending_valid_reg <= 1'b0;
            end
        end
    end

    // read lock between the two byte reads
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_reg <= 1'b0;
        end else if (ce) begin
            lock_reg <= locked_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // done flag: a set in the clearing cycle wins so no completion is missed
    // sticky done flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_reg <= 1'b0;
        end else if (ce) begin
            if (done_set) begin
                done_reg <= 1'b1;
            end else if (done_clear) begin
                done_reg <= 1'b0;
            end
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_reg <= MASK_RESET[DONE_BIT];
        end else if (ce && wr_mask) begin
            mask_reg <= req.wdata[DONE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data; alignment uses the live left-adjust bit, so a change shows at once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else if (ce) begin
            rdata_reg <= '0;
            if (req.read) begin
                unique case (req.addr)
                    SELECT_OFFSET: begin
                        rdata_reg <= select_reg;
                    end
                    RES_LOW_OFFSET: begin
                        if (select_reg.left_adjust_bit) begin
                            rdata_reg <= {result_reg[1:0], 6'h00};
                        end else begin
                            rdata_reg <= result_reg[7:0];
                        end
                    end
                    RES_HIGH_OFFSET: begin
                        if (select_reg.left_adjust_bit) begin
                            rdata_reg <= result_reg[9:2];
                        end else begin
                            rdata_reg <= {6'h00, result_reg[9:8]};
                        end
                    end
                    STATUS_OFFSET: begin
                        rdata_reg[DONE_BIT] <= done_reg;
                        rdata_reg[BUSY_BIT] <= busy_reg;
                    end
                    MASK_OFFSET: begin
                        rdata_reg[DONE_BIT] <= mask_reg;
                    end
                    default: begin
                        rdata_reg <= '0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata = rdata_reg;
    assign analog_sel = analog_sel_reg;
    assign busy = busy_reg;
    assign irq = done_reg && mask_reg;

endmodule

// >>> verification/adc_select_top_asserts.sv
`timescale 1ns/100ps
// timing checks on selection, conversion span and done flag, from the ports only
module adc_select_top_asserts
    import adc_select_pkg::*;
(
    input wire logic clk,                  // clock
    input wire logic resetn,               // reset, active low
    input wire logic ce,                   // clock enable
    input wire reg_req_t req,              // register request
    input wire logic [DATA_W-1:0] rdata,   // read data
    input wire logic conv_start,           // start pulse
    input wire logic sample_valid,         // converter answer
    input wire logic irq_ack,              // vector serviced
    input wire analog_select_t analog_sel, // mux setting
    input wire logic busy,                 // conversion running
    input wire logic irq                   // interrupt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // a landing result sets the flag again, so clears are judged without one
    wire logic fin = busy && sample_valid;
    ////////////////////////////////////////////////////////////
    // steps of a selection write seen while idle
    sequence s_sel_wr;
        ce && req.write && req.addr == SELECT_OFFSET && !busy && !conv_start;
    endsequence
    sequence s_idle;
        ce && !busy && !conv_start && !(req.write && req.addr == SELECT_OFFSET);
    endsequence
    AST_START_BUSY: assert property (
        ce && conv_start && !busy |=> busy)
        else $error("start not taken");
    AST_SEL_HELD: assert property (
        busy ##1 busy |-> $stable(analog_sel))
        else $error("selection moved during conversion");
    AST_FINISH: assert property (
        ce && busy && sample_valid |=> !busy)
        else $error("busy stayed after answer");
    AST_ACK_CLEAR: assert property (
        ce && irq_ack && !fin && !req.read |=> !irq)
        else $error("service left interrupt up");
    AST_W1C: assert property (
        ce && req.write && req.addr == STATUS_OFFSET && req.wdata[DONE_BIT] && !fin
        && !req.read |=> !irq)
        else $error("write one did not clear flag");
    AST_MASK_OFF: assert property (
        ce && req.write && req.addr == MASK_OFFSET && !req.wdata[0] |=> !irq)
        else $error("masked interrupt still up");
    AST_REF_FOLLOW: assert property (
        s_sel_wr ##1 s_idle |=> analog_sel.reference == $past(req.wdata[7:6], 2))
        else $error("reference not applied");
    AST_SEL_READBACK: assert property (
        s_sel_wr ##1 (ce && req.read && req.addr == SELECT_OFFSET)
        |=> rdata == $past(req.wdata, 2))
        else $error("select readback wrong");
endmodule
bind adc_select_top adc_select_top_asserts u_adc_select_top_asserts (
    .clk(clk), .resetn(resetn), .ce(ce), .req(req), .rdata(rdata),
    .conv_start(conv_start), .sample_valid(sample_valid), .irq_ack(irq_ack),
    .analog_sel(analog_sel), .busy(busy), .irq(irq));

// >>> verification/adc_src_model.sv
`timescale 1ns/100ps
// analog pins and reference: answers each busy span with one sample
module adc_src_model
    import adc_select_pkg::*;
(
    input wire logic clk,                   // clock
    input wire logic resetn,                // reset, active low
    input wire logic busy,                  // conversion running
    input wire analog_select_t analog_sel,  // mux setting
    input wire logic signed [15:0] pin [8], // pin levels, 1024ths of reference
    input wire logic signed [15:0] bandgap, // bandgap level, same units
    input wire logic [7:0] lat,             // cycles before the answer
    output logic sample_valid,              // answer pulse
    output logic signed [15:0] sample_data  // raw sample
);
    logic [7:0] cnt;
    logic signed [15:0] vp;
    ////////////////////////////////////////////////////////////
    // bandgap and ground sources
    assign vp = analog_sel.source == SRC_BANDGAP ? bandgap :
        (analog_sel.source == SRC_GROUND ? 16'sh0000 : pin[analog_sel.positive_input]);
    // sample scaled before gain; data toggles outside the answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
            sample_valid <= 1'b0;
            sample_data <= 16'sh0000;
        end else if (busy && !sample_valid && cnt >= lat) begin
            cnt <= 8'h00;
            sample_valid <= 1'b1;
            sample_data <= analog_sel.differential ? (vp - pin[analog_sel.negative_input]) / 2 : vp;
        end else begin
            cnt <= busy ? cnt + 8'h01 : 8'h00;
            sample_valid <= 1'b0;
            sample_data <= ~sample_data;
        end
    end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top
    import adc_select_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    reg_req_t req = '0;
    logic conv_start = 1'b0;
    logic irq_ack = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic sample_valid, busy, irq;
    logic signed [15:0] sample_data;
    analog_select_t analog_sel;
    logic signed [15:0] pin [8];
    logic signed [15:0] bandgap = 16'sh01C2;
    logic [7:0] lat = 8'h00;
    int n_errors = 0;
    int num_checks = 0;
    int seed = 32'h1dcf;
    int k;
    logic [7:0] exp_q[$];
    string nm_q[$];
    logic rd_seen = 1'b0;
    logic [9:0] r;
    logic [7:0] sel, e;
    string n;
    always #2 clk = ~clk;
    adc_select_top u_adc_select_top (.clk(clk), .resetn(resetn), .ce(ce), .req(req),
        .rdata(rdata), .conv_start(conv_start), .sample_valid(sample_valid),
        .sample_data(sample_data), .irq_ack(irq_ack), .analog_sel(analog_sel),
        .busy(busy), .irq(irq));
    adc_src_model u_adc_src_model (.clk(clk), .resetn(resetn), .busy(busy),
        .analog_sel(analog_sel), .pin(pin), .bandgap(bandgap), .lat(lat),
        .sample_valid(sample_valid), .sample_data(sample_data));
    ////////////////////////////////////////////////////////////
    function automatic logic [9:0] clamp(input int v, input int lo, input int hi);
        return 10'(v < lo ? lo : (v > hi ? hi : v));
    endfunction
    // expected code of an input field with the current pin levels
    function automatic logic [9:0] expect_code(input logic [4:0] c);
        int p, m, g;
        p = c[2:0];
        m = 0;
        g = 1;
        case (c[4:3])
            2'b00: return clamp(pin[p], 0, SE_MAX);
            // gain pairs on input 0 or 2
            2'b01: begin
                m = c[2] ? 2 : 0;
                p = m + c[0];
                g = c[1] ? 200 : 10;
            end
            2'b10: m = 1;
            // pairs on input 2, then bandgap and ground
            default: begin
                if (c[2:1] == 2'b11) return c[0] ? 10'h000 : clamp(bandgap, 0, SE_MAX);
                m = 2;
            end
        endcase
        return clamp((pin[p] - pin[m]) / 2 * g, DIFF_MIN, DIFF_MAX);
    endfunction
    function automatic logic [7:0] lo_b(input logic [9:0] v, input logic la);
        return la ? {v[1:0], 6'h00} : v[7:0];
    endfunction
    function automatic logic [7:0] hi_b(input logic [9:0] v, input logic la);
        return la ? v[9:2] : {6'h00, v[9:8]};
    endfunction
    // one strobe cycle then a quiet cycle, so strobes never get assigned twice at once
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        req <= '{a, d, w, !w};
        @(posedge clk);
        req.write <= 1'b0;
        req.read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input string s);
        exp_q.push_back(x);
        nm_q.push_back(s);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic read_res(input logic [9:0] v, input logic la);
        rd(RES_LOW_OFFSET, lo_b(v, la), "result low");
        rd(RES_HIGH_OFFSET, hi_b(v, la), "result high");
    endtask
    task automatic newpins();
        for (int i = 0; i < 8; i++) begin
            pin[i] <= 16'($unsigned($random(seed)) % 1100);
        end
    endtask
    task automatic start();
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
        @(posedge clk);
    endtask
    task automatic finish();
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (busy !== 1'b0 && k < 300);
        // a conversion that never ends counts as a mismatch
        `CHK("busy", 1'b0, busy)
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // each read answer is taken against the oldest noted expectation
    always @(posedge clk) begin
        rd_seen <= req.read;
        if (rd_seen) begin
            e = exp_q.pop_front();
            n = nm_q.pop_front();
            `CHK(n, e, rdata)
        end
    end
    // a hang costs one mismatch and ends the run
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    initial begin
        newpins();
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(SELECT_OFFSET, SELECT_RESET, "select");
        rd(STATUS_OFFSET, 8'h00, "status");
        rd(MASK_OFFSET, MASK_RESET, "mask");
        `CHK("analog_sel", ANALOG_SELECT_RESET, analog_sel)
        bus(1'b1, 8'h55, 8'hFF);
        rd(8'h55, 8'h00, "unmapped");
        bus(1'b1, MASK_OFFSET, 8'h01);
        // every input code with random pins and alignment, random reference outside the gain codes
        for (int c = 0; c < 32; c++) begin
            newpins();
            sel = {2'($random(seed)), 1'($random(seed)), 5'(c)};
            // software pairs gain stages with 2.56V
            if (sel[4:3] == 2'b01) sel[7:6] = 2'b11;
            // write and readback back to back, no gap between the strobes
            req <= '{SELECT_OFFSET, sel, 1'b1, 1'b0};
            @(posedge clk);
            rd(SELECT_OFFSET, sel, "select");
            `CHK("reference", sel[7:6], analog_sel.reference)
            start();
            finish();
            `CHK("irq", 1'b1, irq)
            read_res(expect_code(sel[4:0]), sel[5]);
            bus(1'b1, STATUS_OFFSET, 8'h01);
            rd(STATUS_OFFSET, 8'h00, "status");
        end
        // selection written mid-conversion waits, alignment changes at once
        bus(1'b1, SELECT_OFFSET, 8'h43);
        start();
        finish();
        r = expect_code(5'h03);
        newpins();
        lat <= 8'h1E;
        start();
        bus(1'b1, SELECT_OFFSET, 8'hA5);
        read_res(r, 1'b1);
        rd(STATUS_OFFSET, 8'h03, "status");
        `CHK("held ref", 2'h1, analog_sel.reference)
        `CHK("held input", 3'h3, analog_sel.positive_input)
        finish();
        read_res(expect_code(5'h03), 1'b1);
        `CHK("new ref", 2'h2, analog_sel.reference)
        start();
        finish();
        r = expect_code(5'h05);
        read_res(r, 1'b1);
        // a low-byte read parks the next result until the high byte is read
        bus(1'b1, STATUS_OFFSET, 8'h01);
        newpins();
        start();
        rd(RES_LOW_OFFSET, lo_b(r, 1'b1), "result low");
        finish();
        `CHK("irq parked", 1'b0, irq)
        rd(RES_HIGH_OFFSET, hi_b(r, 1'b1), "result high");
        read_res(expect_code(5'h05), 1'b1);
        `CHK("irq loaded", 1'b1, irq)
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        @(posedge clk);
        `CHK("irq ack", 1'b0, irq)
        bus(1'b1, MASK_OFFSET, 8'h00);
        lat <= 8'h00;
        start();
        finish();
        `CHK("irq masked", 1'b0, irq)
        rd(STATUS_OFFSET, 8'h01, "status");
        // a write while the clock enable is low must be lost
        ce <= 1'b0;
        bus(1'b1, SELECT_OFFSET, 8'hFF);
        ce <= 1'b1;
        rd(SELECT_OFFSET, 8'hA5, "select frozen");
        // let the monitor take the last read before the run ends
        @(posedge clk);
        give_verdict();
    end
endmodule
